// ==== rtl/edge_separation_encoder_counter.sv ====
// counter input channel: two-edge separation, quadrature and two-pulse encoders
// assumes pins are asynchronous to clk; cfg, start and stop come from clk logic
//
// How it works
// - single mode: ticks from a first-signal rise to the next second-signal rise load first_to_second at that rise.
// - single mode: ticks from a second-signal rise to the next first-signal rise load second_to_first at that rise.
// - buffered internal clock: each sample clock rise pushes the latest first-to-second count.
// - buffered implicit clock: each first-signal rise pushes the latest separation count.
// - x1 decoding counts up on A rising with B low and down on A falling with B low.
// - x2 decoding counts on both A edges, up when A leads B and down when B leads A.
// - x4 decoding counts on every edge of A and B, up when A leads and down when B leads.
// - the quadrature count reloads while index is high and both phases are low.
// - the decode input selects x1, x2 or x4.
// - single mode quadrature: the readable count is updated at each A rise.
// - buffered internal clock for both encoders: each sample clock rise pushes the count.
// - buffered implicit clock for both encoders: every change of the count pushes it.
// - the two-pulse encoder counts up on each A rise and down on each B rise, and holds when A and B rise in the same cycle.
// - single mode two-pulse: the readable count is updated at each A rise and each B rise.
// - buffered results are clocked either by the internal sample clock or implicitly by the signal.
`timescale 1ns/1ns
`default_nettype none
module edge_separation_encoder_counter
  import edge_sep_counter_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               counter_source_phase_a_input,
  input  wire logic               counter_aux_phase_b_input,
  input  wire logic               counter_gate_index_input,
  input  wire logic               sample_clock_input,
  input  wire cfg_s               cfg,
  input  wire logic               start,
  input  wire logic               stop,
  output logic      [COUNT_W-1:0] first_to_second,
  output logic      [COUNT_W-1:0] second_to_first,
  output logic      [COUNT_W-1:0] count_value,
  output logic                    running,
  output logic                    done,
  output logic                    overflow,
  output logic                    sample_valid,
  input  wire logic               sample_ready,
  output sample_s                 sample_data
);

  typedef struct packed {
    logic [SYNC_DEPTH-1:0] a_sy;
    logic [SYNC_DEPTH-1:0] b_sy;
    logic [SYNC_DEPTH-1:0] z_sy;
    logic [SYNC_DEPTH-1:0] s_sy;
    logic                  a_l;
    logic                  b_l;
    logic                  z_l;
    logic                  s_l;
    logic                  running;
    logic                  done;
    logic                  overflow;
    logic [COUNT_W-1:0]    tick_f2s;
    logic [COUNT_W-1:0]    tick_s2f;
    logic [COUNT_W-1:0]    f2s;
    logic [COUNT_W-1:0]    s2f;
    logic [COUNT_W-1:0]    count;
    logic [COUNT_W-1:0]    count_value;
    logic [COUNT_W-1:0]    left;
  } state_s;

  state_s  st;
  state_s  next_st;
  logic    a_rise;
  logic    a_fall;
  logic    b_rise;
  logic    b_fall;
  logic    z_rise;
  logic    s_rise;
  logic    reload;
  logic    push_req;
  logic    push_ok;
  logic    buf_ready;
  sample_s push_word;
  logic [1:0] step;

  // held level moves only when the second and third stages agree
  function automatic logic settled(input logic [SYNC_DEPTH-1:0] sy);
    settled = (sy[1] == sy[2]);
  endfunction : settled

  function automatic logic rises(input logic [SYNC_DEPTH-1:0] sy, input logic l);
    rises = settled(sy) && sy[2] && !l;
  endfunction : rises

  function automatic logic falls(input logic [SYNC_DEPTH-1:0] sy, input logic l);
    falls = settled(sy) && !sy[2] && l;
  endfunction : falls

  function automatic logic [COUNT_W-1:0] sat_inc(input logic [COUNT_W-1:0] v);
    sat_inc = (v == COUNT_MAX) ? v : v + COUNT_ONE;
  endfunction : sat_inc

  // step code: 2'b01 up, 2'b11 down, 2'b00 none
  function automatic logic [1:0] quad_step(input decode_e d, input logic ar, input logic af,
                                           input logic br, input logic bf,
                                           input logic a, input logic b);
    quad_step = 2'b00;
    if ((ar || af) && (br || bf)) begin
      quad_step = 2'b00; // both phases moved at once: position unknown, hold
    end else begin
      case (d)
        DEC_X1: begin
          if (ar && !b) quad_step = 2'b01;
          if (af && !b) quad_step = 2'b11;
        end
        DEC_X2: begin
          if (ar) quad_step = b ? 2'b11 : 2'b01;
          if (af) quad_step = b ? 2'b01 : 2'b11;
        end
        DEC_X4: begin
          if (ar) quad_step = b ? 2'b11 : 2'b01;
          if (af) quad_step = b ? 2'b01 : 2'b11;
          if (br) quad_step = a ? 2'b01 : 2'b11;
          if (bf) quad_step = a ? 2'b11 : 2'b01;
        end
        default: quad_step = 2'b00;
      endcase
    end
  endfunction : quad_step

  assign a_rise = rises(st.a_sy, st.a_l);
  assign a_fall = falls(st.a_sy, st.a_l);
  assign b_rise = rises(st.b_sy, st.b_l);
  assign b_fall = falls(st.b_sy, st.b_l);
  assign z_rise = rises(st.z_sy, st.z_l);
  assign s_rise = rises(st.s_sy, st.s_l);

  // index is read at its held level so a short glitch cannot reload
  assign reload = st.z_l && !st.a_l && !st.b_l;

  always_comb begin
    next_st   = st;
    step      = 2'b00;
    push_req  = 1'b0;
    push_word = '0;

    next_st.a_sy = {st.a_sy[SYNC_DEPTH-2:0], counter_source_phase_a_input};
    next_st.b_sy = {st.b_sy[SYNC_DEPTH-2:0], counter_aux_phase_b_input};
    next_st.z_sy = {st.z_sy[SYNC_DEPTH-2:0], counter_gate_index_input};
    next_st.s_sy = {st.s_sy[SYNC_DEPTH-2:0], sample_clock_input};
    if (settled(st.a_sy)) next_st.a_l = st.a_sy[2];
    if (settled(st.b_sy)) next_st.b_l = st.b_sy[2];
    if (settled(st.z_sy)) next_st.z_l = st.z_sy[2];
    if (settled(st.s_sy)) next_st.s_l = st.s_sy[2];

    // separation: first signal on the gate/index pin, second on phase B
    next_st.tick_f2s = z_rise ? COUNT_ONE : sat_inc(st.tick_f2s);
    next_st.tick_s2f = b_rise ? COUNT_ONE : sat_inc(st.tick_s2f);
    if (b_rise) next_st.f2s = st.tick_f2s;
    if (z_rise) next_st.s2f = st.tick_s2f;

    case (cfg.func)
      FN_QUAD: begin
        step = quad_step(cfg.decode, a_rise, a_fall, b_rise, b_fall, st.a_l, st.b_l);
        if (reload) begin
          next_st.count = cfg.reload_value;
        end else if (step == 2'b01) begin
          next_st.count = st.count + COUNT_ONE;
        end else if (step == 2'b11) begin
          next_st.count = st.count - COUNT_ONE;
        end
        if (cfg.readout == single_readout_mode && a_rise) begin
          next_st.count_value = next_st.count;
        end
      end
      FN_TWO_PULSE: begin
        if (a_rise && !b_rise) next_st.count = st.count + COUNT_ONE;
        if (b_rise && !a_rise) next_st.count = st.count - COUNT_ONE;
        if (cfg.readout == single_readout_mode && (a_rise || b_rise)) begin
          next_st.count_value = next_st.count;
        end
      end
      default: ;
    endcase

    // sample source chosen by readout mode
    case (cfg.readout)
      RD_BUF_INTERNAL: begin
        push_req = st.running && s_rise;
      end
      RD_BUF_IMPLICIT: begin
        if (cfg.func == FN_EDGE_SEP) begin
          push_req = st.running && z_rise;
        end else begin
          push_req = st.running && (next_st.count != st.count);
        end
      end
      default: push_req = 1'b0;
    endcase
    push_word.kind  = cfg.func;
    push_word.value = (cfg.func == FN_EDGE_SEP) ? st.f2s : next_st.count;

    // a full buffer drops the word and says so rather than stalling the count
    if (push_req && !buf_ready) next_st.overflow = 1'b1;
    if (push_ok && cfg.finite) begin
      next_st.left = st.left - COUNT_ONE;
      if (st.left == COUNT_ONE) begin
        next_st.running = 1'b0;
        next_st.done    = 1'b1;
      end
    end
    if (stop) next_st.running = 1'b0;
    if (start) begin
      next_st.running  = (cfg.readout != single_readout_mode) && !(cfg.finite && cfg.sample_count == '0);
      next_st.done     = 1'b0;
      next_st.overflow = 1'b0;
      next_st.left     = cfg.sample_count;
    end
  end

  assign push_ok = push_req && buf_ready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  sample_skid_buffer #(
    .WIDTH (SAMPLE_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_req),
    .in_ready  (buf_ready),
    .in_data   (push_word),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  (sample_data)
  );

  assign first_to_second = st.f2s;
  assign second_to_first = st.s2f;
  assign count_value     = st.count_value;
  assign running         = st.running;
  assign done            = st.done;
  assign overflow        = st.overflow;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  f2s_load_a: assert property (b_rise |=> first_to_second == $past(st.tick_f2s))
    else $error("first_to_second not loaded on second-signal rise");
  s2f_load_a: assert property (z_rise |=> second_to_first == $past(st.tick_s2f))
    else $error("second_to_first not loaded on first-signal rise");
  x1_up_a: assert property (cfg.func == FN_QUAD && cfg.decode == DEC_X1 && a_rise && !st.b_l
                            && !b_rise && !b_fall && !reload |=> st.count == $past(st.count) + COUNT_ONE)
    else $error("x1 did not count up");
  x2_down_a: assert property (cfg.func == FN_QUAD && cfg.decode == DEC_X2 && a_fall && !st.b_l
                              && !b_rise && !b_fall && !reload |=> st.count == $past(st.count) - COUNT_ONE)
    else $error("x2 did not count down");
  x4_b_edge_a: assert property (cfg.func == FN_QUAD && cfg.decode == DEC_X4 && b_rise && st.a_l
                                && !a_rise && !a_fall && !reload |=> st.count == $past(st.count) + COUNT_ONE)
    else $error("x4 did not count on B rise");
  index_reload_a: assert property (cfg.func == FN_QUAD && reload |=> st.count == $past(cfg.reload_value))
    else $error("index reload missed");
  pulse_count_a: assert property (cfg.func == FN_TWO_PULSE && b_rise && !a_rise
                                  |=> st.count == $past(st.count) - COUNT_ONE)
    else $error("two-pulse did not count down on B");
  single_read_a: assert property (cfg.func == FN_TWO_PULSE && cfg.readout == single_readout_mode
                                  && (a_rise || b_rise) |=> count_value == st.count)
    else $error("readable count not refreshed");
  sample_push_a: assert property (cfg.readout == RD_BUF_INTERNAL && running && s_rise && buf_ready
                                  |=> sample_valid)
    else $error("sample clock rise pushed nothing");
  finite_stop_a: assert property (cfg.finite && push_ok && st.left == COUNT_ONE && !start
                                  |=> !running && done && !push_ok)
    else $error("finite run did not stop");
  sync_agree_a: assert property ($changed(st.a_l) |-> $past(st.a_sy[1]) == $past(st.a_sy[2]))
    else $error("phase A level moved without agreement");

  // tick counters restart at one and saturate so a lost edge never yields a small bogus spacing
  tick_start_a: assert property (z_rise |=> st.tick_f2s == COUNT_ONE)
    else $error("first-to-second ticks did not restart");
  tick_run_a: assert property (!z_rise && st.tick_f2s != COUNT_MAX
                               |=> st.tick_f2s == $past(st.tick_f2s) + COUNT_ONE)
    else $error("first-to-second ticks did not advance");
  tick_s2f_a: assert property (b_rise |=> st.tick_s2f == COUNT_ONE)
    else $error("second-to-first ticks did not restart");
  x1_down_a: assert property (cfg.func == FN_QUAD && cfg.decode == DEC_X1 && a_fall && !st.b_l
                              && !b_rise && !b_fall |=> st.count == $past(st.count) - COUNT_ONE)
    else $error("x1 did not count down");
  x1_ignore_a: assert property (cfg.func == FN_QUAD && cfg.decode == DEC_X1 && (a_rise || a_fall)
                                && st.b_l |=> $stable(st.count))
    else $error("x1 counted with phase B high");
  x2_up_a: assert property (cfg.func == FN_QUAD && cfg.decode == DEC_X2 && a_rise && !st.b_l
                            && !b_rise && !b_fall && !reload |=> st.count == $past(st.count) + COUNT_ONE)
    else $error("x2 did not count up");
  x2_b_quiet_a: assert property (cfg.func == FN_QUAD && cfg.decode == DEC_X2 && !reload
                                 && !a_rise && !a_fall |=> $stable(st.count))
    else $error("x2 counted without an A edge");
  x4_b_fall_a: assert property (cfg.func == FN_QUAD && cfg.decode == DEC_X4 && b_fall && st.a_l
                                && !a_rise && !a_fall |=> st.count == $past(st.count) - COUNT_ONE)
    else $error("x4 did not count down on B fall");
  quad_read_a: assert property (cfg.func == FN_QUAD && cfg.readout == single_readout_mode && a_rise
                                |=> count_value == st.count)
    else $error("count register not refreshed on A rise");
  quad_read_hold_a: assert property (cfg.func == FN_QUAD && !a_rise |=> $stable(count_value))
    else $error("count register moved without an A rise");
  pulse_up_a: assert property (cfg.func == FN_TWO_PULSE && a_rise && !b_rise
                               |=> st.count == $past(st.count) + COUNT_ONE)
    else $error("two-pulse did not count up on A");
  pulse_hold_a: assert property (cfg.func == FN_TWO_PULSE && a_rise == b_rise |=> $stable(st.count))
    else $error("two-pulse count moved without a single rise");
  pulse_read_hold_a: assert property (cfg.func == FN_TWO_PULSE && !a_rise && !b_rise
                                      |=> $stable(count_value))
    else $error("count register moved without a rise");
  sep_internal_a: assert property (cfg.func == FN_EDGE_SEP && cfg.readout == RD_BUF_INTERNAL && running
                                   && s_rise && !sample_valid |=> sample_data.value == $past(first_to_second))
    else $error("sample clock pushed the wrong separation");
  sep_implicit_a: assert property (cfg.func == FN_EDGE_SEP && cfg.readout == RD_BUF_IMPLICIT && running
                                   && z_rise && !sample_valid
                                   |=> sample_valid && sample_data.value == $past(first_to_second))
    else $error("first-signal rise pushed the wrong separation");
  enc_internal_a: assert property (cfg.func != FN_EDGE_SEP && cfg.readout == RD_BUF_INTERNAL && running
                                   && s_rise && !sample_valid |=> sample_data.value == st.count)
    else $error("sample clock pushed the wrong count");
  enc_implicit_a: assert property (cfg.func != FN_EDGE_SEP && cfg.readout == RD_BUF_IMPLICIT && running
                                   && next_st.count != st.count && !sample_valid
                                   |=> sample_valid && sample_data.value == st.count)
    else $error("count change pushed nothing");
  idle_quiet_a: assert property (!running && !sample_valid |=> !sample_valid)
    else $error("word pushed while not running");
  single_idle_a: assert property (start && cfg.readout == single_readout_mode |=> !running)
    else $error("single mode armed the buffer");
  start_arm_a: assert property (start && cfg.readout != single_readout_mode && !cfg.finite
                                |=> running && !done && !overflow)
    else $error("start did not arm a continuous run");
  stop_halt_a: assert property (stop && !start |=> !running)
    else $error("stop did not end the run");
  done_hold_a: assert property (done && !start |=> done)
    else $error("done dropped without a start");
  overflow_hold_a: assert property (overflow && !start |=> overflow)
    else $error("overflow dropped without a start");
  sync_b_a: assert property ($changed(st.b_l) |-> $past(st.b_sy[1]) == $past(st.b_sy[2]))
    else $error("phase B level moved without agreement");
  sync_z_a: assert property ($changed(st.z_l) |-> $past(st.z_sy[1]) == $past(st.z_sy[2]))
    else $error("index level moved without agreement");

endmodule : edge_separation_encoder_counter
`default_nettype wire

// ==== rtl/edge_sep_counter_pkg.sv ====
// constants, modes and carrier types for the counter input channel
// assumes a single 25 MHz timebase clock drives every user of this package
package edge_sep_counter_pkg;

  localparam int unsigned TIMEBASE_PERIOD_NS = 40;
  localparam int unsigned TIMEBASE_HZ        = 1000000000 / TIMEBASE_PERIOD_NS;

  localparam int unsigned COUNT_W    = 32;
  localparam int unsigned BUF_DEPTH  = 2;
  localparam int unsigned SYNC_DEPTH = 3;

  localparam logic [COUNT_W-1:0] COUNT_RESET  = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE    = 32'h0000_0001;
  localparam logic [COUNT_W-1:0] COUNT_MAX    = 32'hFFFF_FFFF;
  localparam logic [1:0]         SYNC_RESET   = 2'h0;

  typedef enum logic [1:0] {
    FN_EDGE_SEP,
    FN_QUAD,
    FN_TWO_PULSE
  } function_e;

  typedef enum logic [1:0] {
    single_readout_mode,
    RD_BUF_INTERNAL,
    RD_BUF_IMPLICIT
  } readout_e;

  typedef enum logic [1:0] {
    DEC_X1,
    DEC_X2,
    DEC_X4
  } decode_e;

  typedef struct packed {
    function_e          func;
    readout_e           readout;
    decode_e            decode;
    logic               finite;
    logic [COUNT_W-1:0] sample_count;
    logic [COUNT_W-1:0] reload_value;
  } cfg_s;

  typedef struct packed {
    logic [1:0]         kind;
    logic [COUNT_W-1:0] value;
  } sample_s;

  localparam int unsigned SAMPLE_W = $bits(sample_s);

endpackage : edge_sep_counter_pkg

// ==== rtl/sample_skid_buffer.sv ====
// small valid/ready buffer holding samples between the counter and its reader
// assumes both sides run on clk; the reader may stall at any time
`timescale 1ns/1ns
`default_nettype none
module sample_skid_buffer
  import edge_sep_counter_pkg::*;
#(
  parameter int unsigned WIDTH = SAMPLE_W,
  parameter int unsigned DEPTH = BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FILL_FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST  = PW'(DEPTH - 1);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   fill;
  } state_s;

  state_s             st;
  state_s             next_st;
  logic   [WIDTH-1:0] mem [DEPTH];
  logic               push;
  logic               pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PTR_LAST) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  assign in_ready  = (st.fill != FILL_FULL);
  assign out_valid = (st.fill != '0);
  assign out_data  = mem[st.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = ptr_inc(st.wr_ptr);
    end
    if (pop) begin
      next_st.rd_ptr = ptr_inc(st.rd_ptr);
    end
    case ({push, pop})
      2'b10:   next_st.fill = st.fill + (PW+1)'(1);
      2'b01:   next_st.fill = st.fill - (PW+1)'(1);
      default: next_st.fill = st.fill;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wr_ptr] <= in_data;
    end
  end

endmodule : sample_skid_buffer
`default_nettype wire

// ==== dv/signal_source_model.sv ====
// partner model: encoder, pulse and sample-clock sources on the counter pins
// assumes the bench steps it from falling edges of clk
`timescale 1ns/1ns
`default_nettype none
module signal_source_model (
  input  wire logic clk,
  output var logic  phase_a,
  output var logic  phase_b,
  output var logic  index_z,
  output var logic  sample_clk
);
  initial begin
    {phase_a, phase_b, index_z, sample_clk} = 4'h0;
  end
  // levels change just after a falling edge and stand whole cycles;
  // holds under 2 cycles would slip past the synchronisers, so callers use 4 or more
  task automatic drive(input logic [3:0] lv, input int hold);
    @(negedge clk);
    {phase_a, phase_b, index_z, sample_clk} = lv;
    repeat (hold - 1) @(negedge clk);
  endtask : drive
endmodule : signal_source_model
`default_nettype wire

// ==== dv/edge_separation_encoder_counter_test.sv ====
// self-checking bench for the counter input channel
// assumes signal_source_model drives the pins; stream checked through an expectation queue
`timescale 1ns/1ns
`default_nettype none
module edge_separation_encoder_counter_test;
  import edge_sep_counter_pkg::*;
  logic                clk;
  logic                sys_rst;
  wire logic           pa;
  wire logic           pb;
  wire logic           pz;
  wire logic           ps;
  cfg_s                cfg;
  logic                start;
  logic                stop;
  logic [COUNT_W-1:0]  first_to_second;
  logic [COUNT_W-1:0]  second_to_first;
  logic [COUNT_W-1:0]  count_value;
  logic                running;
  logic                done;
  logic                overflow;
  logic                sample_valid;
  logic                sample_ready;
  sample_s             sample_data;
  logic                stall;
  logic [31:0]         rnd = 32'h03DB;
  logic [31:0]         cnt;
  logic [1:0]          ab;
  logic [1:0]          nab;
  logic [SAMPLE_W-1:0] exp_q[$];
  int                  err_total;
  int                  num_checks;
  int                  i;
  int                  d;
  int                  n;
  int                  m;
  int                  delta;
  // forward (a leads) then reverse (b leads) quadrature steps as {a, b}
  logic [1:0] gray [8] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h1, 2'h3, 2'h2, 2'h0};

  signal_source_model src (.clk(clk), .phase_a(pa), .phase_b(pb), .index_z(pz), .sample_clk(ps));

  edge_separation_encoder_counter u_edge_separation_encoder_counter (
    .clk(clk), .sys_rst(sys_rst), .counter_source_phase_a_input(pa), .counter_aux_phase_b_input(pb),
    .counter_gate_index_input(pz), .sample_clock_input(ps), .cfg(cfg), .start(start), .stop(stop),
    .first_to_second(first_to_second), .second_to_first(second_to_first), .count_value(count_value),
    .running(running), .done(done), .overflow(overflow), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data));

  always #20 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // change of count for one step; x1 ignores a-edges while b is high
  function automatic int step_delta(input decode_e dm, input logic [1:0] p, input logic [1:0] q);
    if (p[1] != q[1]) return (dm == DEC_X1) ? (p[0] ? 0 : (q[1] ? 1 : -1)) : ((q[1] ^ p[0]) ? 1 : -1);
    return (dm == DEC_X4) ? ((q[0] ^ p[1]) ? -1 : 1) : 0;
  endfunction : step_delta

  task automatic final_report();
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [SAMPLE_W-1:0] e, input logic [SAMPLE_W-1:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk

  task automatic expect_s(input function_e f, input logic [31:0] v);
    exp_q.push_back({f, v});
  endtask : expect_s

  task automatic wait_idle();
    int k;
    for (k = 0; k < 400 && exp_q.size() > 0; k++) @(negedge clk);
    if (exp_q.size() > 0) begin
      err_total++;
      final_report();
    end
    repeat (4) @(negedge clk);
  endtask : wait_idle

  task automatic rst();
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
  endtask : rst

  task automatic pulse(input logic go);
    @(negedge clk);
    start = go;
    stop = !go;
    @(negedge clk);
    start = 1'b0;
    stop = 1'b0;
  endtask : pulse

  task automatic tp(input logic on_b);
    src.drive(on_b ? 4'h4 : 4'h8, 4);
    src.drive(4'h0, 4);
  endtask : tp

  // first rise, second rise n later, first rise m after that
  task automatic sep_seq(input int fn, input int fm);
    src.drive(4'h2, fn);
    src.drive(4'h4, fm);
    src.drive(4'h2, 6);
    src.drive(4'h0, 6);
  endtask : sep_seq

  // reader takes words at random unless stalled on purpose
  always @(negedge clk) begin
    rnd <= lfsr_next(rnd);
    sample_ready <= !stall && (rnd[1:0] != 2'h0);
  end

  always @(posedge clk) begin
    if (sample_valid === 1'b1 && sample_ready === 1'b1) chk(exp_q.size() ? exp_q.pop_front() : ~sample_data, sample_data);
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cfg = '0;
    start = 1'b0;
    stop = 1'b0;
    stall = 1'b0;
    sample_ready = 1'b0;
    err_total = 0;
    num_checks = 0;
    rst();
    chk(34'h0, {count_value, running, done});
    chk(34'h0, {first_to_second, overflow, sample_valid});
    n = 4 + int'(rnd[3:0]);
    m = 4 + int'(rnd[7:4]);
    sep_seq(n, m);
    chk(34'(n), {2'h0, first_to_second});
    chk(34'(m), {2'h0, second_to_first});
    cfg.readout = RD_BUF_INTERNAL;
    pulse(1'b1);
    expect_s(FN_EDGE_SEP, 32'(n));
    src.drive(4'h1, 4);
    src.drive(4'h0, 6);
    wait_idle();
    pulse(1'b0);
    cfg.readout = RD_BUF_IMPLICIT;
    pulse(1'b1);
    expect_s(FN_EDGE_SEP, 32'(n));
    expect_s(FN_EDGE_SEP, 32'(m));
    sep_seq(m, n);
    wait_idle();
    pulse(1'b0);
    rst();
    cfg = '0;
    cfg.func = FN_QUAD;
    cfg.decode = DEC_X4;
    cfg.reload_value = 32'h0000_0055;
    src.drive(4'h2, 6);
    src.drive(4'h0, 6);
    for (i = 0; i < 4; i++) src.drive({gray[i], 2'h0}, 6);
    chk(34'h56, {2'h0, count_value});
    for (d = 0; d < 3; d++) begin
      cfg.decode = decode_e'(d);
      cfg.readout = RD_BUF_IMPLICIT;
      cfg.reload_value = 32'h0000_0100 + 32'(d);
      src.drive(4'h2, 6);
      src.drive(4'h0, 6);
      pulse(1'b1);
      cnt = cfg.reload_value;
      ab = 2'h0;
      for (i = 0; i < 16; i++) begin
        nab = gray[(i < 8) ? i % 4 : 4 + i % 4];
        delta = step_delta(cfg.decode, ab, nab);
        cnt = cnt + 32'(delta);
        if (delta != 0) expect_s(FN_QUAD, cnt);
        src.drive({nab, 2'h0}, 6);
        ab = nab;
      end
      wait_idle();
      pulse(1'b0);
    end
    rst();
    cfg = '0;
    cfg.func = FN_TWO_PULSE;
    tp(1'b0);
    chk(34'h1, {2'h0, count_value});
    tp(1'b1);
    tp(1'b1);
    chk(34'h0_FFFF_FFFF, {2'h0, count_value});
    cfg.readout = RD_BUF_IMPLICIT;
    @(posedge clk);
    stall = 1'b1;
    pulse(1'b1);
    expect_s(FN_TWO_PULSE, 32'h0);
    expect_s(FN_TWO_PULSE, 32'h1);
    repeat (3) tp(1'b0);
    chk(34'h1, {33'h0, overflow});
    @(posedge clk);
    stall = 1'b0;
    wait_idle();
    pulse(1'b0);
    cfg.finite = 1'b1;
    cfg.sample_count = 32'h0000_0003;
    pulse(1'b1);
    for (i = 3; i < 6; i++) expect_s(FN_TWO_PULSE, 32'(i));
    repeat (4) tp(1'b0);
    wait_idle();
    chk(34'h2, {32'h0, done, running});
    cfg.finite = 1'b0;
    cfg.readout = RD_BUF_INTERNAL;
    pulse(1'b1);
    expect_s(FN_TWO_PULSE, 32'h6);
    src.drive(4'h1, 4);
    src.drive(4'h0, 6);
    wait_idle();
    final_report();
  end
endmodule : edge_separation_encoder_counter_test
`default_nettype wire
